/* File: hw/hdsb_top.sv */
// hub descriptor tail and string descriptor builder, top level
// Functional notes
// - hub descriptor byte 5 is the configured power-on settle time (2 ms units) as stored.
// - hub descriptor byte 6 is the hub controller current in 1 mA steps.
// - byte 6 takes the bus-powered current when the power source bit is 0, self-powered when 1.
// - hub descriptor byte 7 is the configured fixed device mask as stored.
// - hub descriptor byte 8 is always FFh.
// - the maker, product and serial strings hold at most 30 bytes each.
// - string zero is 04h, 03h, then the language code low byte and high byte.
// - strings 1 to 3 start with the stored length plus 2, then type 03h.
// - from offset 2 the stored text follows, index 1 maker, 2 product, 3 serial.
// - hub class requests are answered for type 29h and for the older type 00h.
`timescale 1ns/1ns
module hdsb_top (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        cfg_wr_en,
   input  wire logic        cfg_rd_en,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   output logic      [7:0]  cfg_rdata,
   input  wire logic        req_valid,
   input  wire logic [7:0]  req_type,
   input  wire logic [7:0]  req_index,
   input  wire logic [15:0] req_length,
   output logic             req_ready,
   output logic             resp_valid,
   output logic      [7:0]  resp_data,
   output logic      [7:0]  resp_offset,
   output logic             resp_last,
   output logic             resp_empty,
   output logic             resp_stall
);
   // ---------------------------------------------------------------
   // state and datapath registers
   // ---------------------------------------------------------------
   hdsb_pkg::hdsb_state_t state_q;
   hdsb_pkg::hdsb_state_t state_d;
   hdsb_pkg::hdsb_kind_t  kind_q;
   hdsb_pkg::hdsb_kind_t  kind_w;
   logic [1:0]            sel_q;
   logic [7:0]            start_q;
   logic [7:0]            ofs_q;
   logic [7:0]            limit_q;
   logic [15:0]           req_len_q;
   logic                  req_ready_q;
   logic                  resp_valid_q;
   logic [7:0]            resp_data_q;
   logic [7:0]            resp_offset_q;
   logic                  resp_last_q;
   logic                  resp_empty_q;
   logic                  resp_stall_q;
   logic [7:0]            pick_byte;
   logic [7:0]            pick_len;

   hdsb_cfg_if cfg_bus ();

   hdsb_cfg_regs u_regs (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_en   (cfg_wr_en),
      .rd_en   (cfg_rd_en),
      .addr    (cfg_addr),
      .wdata   (cfg_wdata),
      .rdata_q (cfg_rdata),
      .cfg     (cfg_bus.store)
   );

   hdsb_byte_pick u_pick (
      .kind      (kind_q),
      .sel       (sel_q),
      .offset    (ofs_q),
      .pick_byte (pick_byte),
      .desc_len  (pick_len),
      .cfg       (cfg_bus.pick)
   );

   // ---------------------------------------------------------------
   // request decode
   // ---------------------------------------------------------------
   wire       is_hub  = (req_type == hdsb_pkg::TYPE_HUB) || (req_type == hdsb_pkg::TYPE_HUB_OLD);
   wire       is_text = (req_type == hdsb_pkg::TYPE_STRING);
   wire       take    = req_valid && req_ready_q;
   wire       good    = is_hub || (is_text && (req_index <= hdsb_pkg::STR_MAX_INDEX));
   wire       accept  = take && good;
   wire [1:0] sel_w   = 2'(req_index[1:0] - 2'h1);
   // only the tail of the hub descriptor lives here, so it starts mid-way
   wire [7:0] start_w = is_hub ? hdsb_pkg::OFS_SETTLE : 8'h00;

   assign kind_w = is_hub ? hdsb_pkg::KIND_HUB :
                   (req_index == 8'h00) ? hdsb_pkg::KIND_LANG : hdsb_pkg::KIND_TEXT;

   // the text length is only visible through the picker, hence the sizing cycle
   wire [7:0] limit_w = (req_len_q < {8'h00, pick_len}) ? req_len_q[7:0] : pick_len;
   wire       empty_w = start_q >= limit_w;
   wire       last_w  = (ofs_q + 8'h01) >= limit_q;
   wire       sizing  = state_q == hdsb_pkg::ST_SIZE;
   wire       sending = state_q == hdsb_pkg::ST_SEND;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         hdsb_pkg::ST_IDLE: begin
            if (accept) state_d = hdsb_pkg::ST_SIZE;
         end
         hdsb_pkg::ST_SIZE: begin
            state_d = empty_w ? hdsb_pkg::ST_IDLE : hdsb_pkg::ST_SEND;
         end
         hdsb_pkg::ST_SEND: begin
            if (last_w) state_d = hdsb_pkg::ST_IDLE;
         end
         default: begin
            state_d = hdsb_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) state_q <= hdsb_pkg::ST_IDLE;
      else state_q <= state_d;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         kind_q    <= hdsb_pkg::KIND_HUB;
         sel_q     <= 2'h0;
         start_q   <= 8'h00;
         req_len_q <= 16'h0000;
      end else if (accept) begin
         kind_q    <= kind_w;
         sel_q     <= sel_w;
         start_q   <= start_w;
         req_len_q <= req_length;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         limit_q <= 8'h00;
         ofs_q   <= 8'h00;
      end else if (sizing) begin
         limit_q <= limit_w;
         ofs_q   <= start_q;
      end else if (sending) begin
         ofs_q   <= ofs_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_ready_q   <= 1'b1;
         resp_valid_q  <= 1'b0;
         resp_data_q   <= 8'h00;
         resp_offset_q <= 8'h00;
         resp_last_q   <= 1'b0;
         resp_empty_q  <= 1'b0;
         resp_stall_q  <= 1'b0;
      end else begin
         req_ready_q   <= state_d == hdsb_pkg::ST_IDLE;
         resp_valid_q  <= sending;
         resp_data_q   <= pick_byte;
         resp_offset_q <= ofs_q;
         resp_last_q   <= sending && last_w;
         resp_empty_q  <= sizing && empty_w;
         resp_stall_q  <= take && !good;
      end
   end

   assign req_ready   = req_ready_q;
   assign resp_valid  = resp_valid_q;
   assign resp_data   = resp_data_q;
   assign resp_offset = resp_offset_q;
   assign resp_last   = resp_last_q;
   assign resp_empty  = resp_empty_q;
   assign resp_stall  = resp_stall_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   wire hub_out  = resp_valid && (kind_q == hdsb_pkg::KIND_HUB);
   wire lang_out = resp_valid && (kind_q == hdsb_pkg::KIND_LANG);
   wire text_out = resp_valid && (kind_q == hdsb_pkg::KIND_TEXT);

   a_settle_value: assert property (hub_out && resp_offset == 8'h05 |->
      resp_data == $past(cfg_bus.settle_time)) else $error("settle byte wrong");
   a_current_bus: assert property (hub_out && resp_offset == 8'h06 && !$past(cfg_bus.power_source_select) |->
      resp_data == $past(cfg_bus.ctrl_current_bus_powered)) else $error("bus current wrong");
   a_current_self: assert property (hub_out && resp_offset == 8'h06 && $past(cfg_bus.power_source_select) |->
      resp_data == $past(cfg_bus.ctrl_current_self_powered)) else $error("self current wrong");
   a_removable_mask: assert property (hub_out && resp_offset == 8'h07 |->
      resp_data == $past(cfg_bus.fixed_device_mask)) else $error("removable byte wrong");
   a_power_mask: assert property (hub_out |-> resp_offset >= 8'h05 &&
      (resp_offset != 8'h08 || resp_data == 8'hFF)) else $error("hub tail byte wrong");
   a_text_bound: assert property (text_out |-> resp_offset < 8'h20)
      else $error("string past 30 bytes");
   a_lang_head: assert property (lang_out && resp_offset == 8'h00 ##1 resp_valid |->
      $past(resp_data) == 8'h04 && resp_data == 8'h03) else $error("string zero header wrong");
   a_lang_code: assert property (lang_out && resp_offset == 8'h03 |->
      resp_data == $past(cfg_bus.language_code_high) &&
      $past(resp_data) == $past(cfg_bus.language_code_low, 2)) else $error("language code wrong");
   a_text_length: assert property (text_out && resp_offset == 8'h00 |->
      resp_data == $past(cfg_bus.text_length[sel_q]) + 8'h02) else $error("string length wrong");
   a_text_body: assert property (text_out && resp_offset >= 8'h02 |->
      resp_offset < $past(cfg_bus.text_length[sel_q]) + 8'h02) else $error("text past length");
   // an empty answer shows one cycle after sizing, the first byte one cycle later still
   a_type_accept: assert property (req_valid && req_ready && (req_type == 8'h29 || req_type == 8'h00) |=>
      !req_ready ##1 (resp_empty or (!req_ready ##1 resp_valid))) else $error("hub request not answered");
   a_offset_order: assert property (resp_valid && !resp_last |=>
      resp_valid && resp_offset == $past(resp_offset) + 8'h01) else $error("offsets out of order");
   a_stop_limit: assert property (resp_valid |-> {8'h00, resp_offset} < req_len_q &&
      (!resp_last || resp_offset + 8'h01 == limit_q)) else $error("transfer overran");

   c_hub_done:  cover property (hub_out && resp_offset == 8'h08 && resp_last);
   c_lang_done: cover property (lang_out && resp_offset == 8'h03 && resp_last);
   c_text_long: cover property (text_out && resp_offset == 8'h1F && resp_last);
   c_stalled:   cover property (resp_stall);
endmodule

/* File: hw/hdsb_pkg.sv */
// constants and types shared by the hub descriptor and string builder
package hdsb_pkg;
   // ---------------------------------------------------------------
   // configuration register map
   // ---------------------------------------------------------------
   localparam int          N_SCALAR      = 7;
   localparam int          IX_CONFIG_ONE = 0;
   localparam int          IX_CUR_BUS    = 1;
   localparam int          IX_CUR_SELF   = 2;
   localparam int          IX_SETTLE     = 3;
   localparam int          IX_FIXED_MASK = 4;
   localparam int          IX_LANG_HI    = 5;
   localparam int          IX_LANG_LO    = 6;
   // entry order follows the IX_ indices above
   localparam logic [6:0][7:0] OFS_SCALAR = {8'h13, 8'h12, 8'h11, 8'h10, 8'h0E, 8'h0F, 8'h06};
   localparam logic [6:0][7:0] RST_SCALAR = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [2:0]  POS_POWER_SOURCE = 3'h7;
   localparam logic [2:0][7:0] OFS_TEXT_LEN  = {8'h16, 8'h15, 8'h14};
   localparam logic [2:0][7:0] OFS_TEXT_BASE = {8'h60, 8'h40, 8'h20};
   localparam logic [7:0]  RST_TEXT_LEN  = 8'h00;
   localparam logic [7:0]  RST_TEXT_BYTE = 8'h00;
   localparam int          TEXT_DEPTH    = 30;
   localparam logic [7:0]  TEXT_MAX      = 8'h1E;
   // ---------------------------------------------------------------
   // descriptor layout
   // ---------------------------------------------------------------
   localparam logic [7:0]  TYPE_HUB       = 8'h29;
   localparam logic [7:0]  TYPE_HUB_OLD   = 8'h00;
   localparam logic [7:0]  TYPE_STRING    = 8'h03;
   localparam logic [7:0]  STR_MAX_INDEX  = 8'h03;
   localparam logic [7:0]  HUB_DESC_LEN   = 8'h09;
   localparam logic [7:0]  OFS_SETTLE     = 8'h05;
   localparam logic [7:0]  OFS_CURRENT    = 8'h06;
   localparam logic [7:0]  OFS_REMOVABLE  = 8'h07;
   localparam logic [7:0]  OFS_PWR_MASK   = 8'h08;
   localparam logic [7:0]  PWR_MASK_VALUE = 8'hFF;
   localparam logic [7:0]  LANG_DESC_LEN  = 8'h04;
   localparam logic [7:0]  STR_HDR_LEN    = 8'h02;
   localparam logic [7:0]  OFS_LANG_LO    = 8'h02;
   localparam logic [7:0]  OFS_LANG_HI    = 8'h03;

   typedef enum logic [1:0] {
      KIND_HUB  = 2'h0,
      KIND_LANG = 2'h1,
      KIND_TEXT = 2'h3
   } hdsb_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SIZE = 2'h1,
      ST_SEND = 2'h3
   } hdsb_state_t;
endpackage

/* File: hw/hdsb_cfg_if.sv */
// configuration values and text read port between store and byte picker
`timescale 1ns/1ns
interface hdsb_cfg_if;
   logic            power_source_select;
   logic [7:0]      ctrl_current_bus_powered;
   logic [7:0]      ctrl_current_self_powered;
   logic [7:0]      settle_time;
   logic [7:0]      fixed_device_mask;
   logic [7:0]      language_code_high;
   logic [7:0]      language_code_low;
   logic [2:0][7:0] text_length;
   logic [1:0]      text_sel;
   logic [4:0]      text_idx;
   logic [7:0]      text_byte;

   modport store (
      output power_source_select, ctrl_current_bus_powered, ctrl_current_self_powered,
      output settle_time, fixed_device_mask, language_code_high, language_code_low,
      output text_length, text_byte,
      input  text_sel, text_idx
   );
   modport pick (
      input  power_source_select, ctrl_current_bus_powered, ctrl_current_self_powered,
      input  settle_time, fixed_device_mask, language_code_high, language_code_low,
      input  text_length, text_byte,
      output text_sel, text_idx
   );
endinterface

/* File: hw/hdsb_cfg_regs.sv */
// configuration store loaded by the reset default or the parallel register write port
`timescale 1ns/1ns
module hdsb_cfg_regs (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata_q,
   hdsb_cfg_if.store       cfg
);
   logic [7:0] reg_q      [hdsb_pkg::N_SCALAR];
   logic [7:0] text_len_q [3];
   logic [7:0] text_q     [3][hdsb_pkg::TEXT_DEPTH];

   // over-long lengths are clipped so a string never reads past its storage
   wire  [7:0] len_clip = (wdata > hdsb_pkg::TEXT_MAX) ? hdsb_pkg::TEXT_MAX : wdata;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   for (genvar r = 0; r < hdsb_pkg::N_SCALAR; r++) begin : g_reg
      wire hit = wr_en && (addr == hdsb_pkg::OFS_SCALAR[r]);
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) reg_q[r] <= hdsb_pkg::RST_SCALAR[r];
         else if (hit) reg_q[r] <= wdata;
      end
   end

   for (genvar s = 0; s < 3; s++) begin : g_text
      wire len_hit = wr_en && (addr == hdsb_pkg::OFS_TEXT_LEN[s]);
      always_ff @(posedge ref_clk or negedge rst_b) begin
         if (!rst_b) text_len_q[s] <= hdsb_pkg::RST_TEXT_LEN;
         else if (len_hit) text_len_q[s] <= len_clip;
      end
      for (genvar b = 0; b < hdsb_pkg::TEXT_DEPTH; b++) begin : g_byte
         wire hit = wr_en && (addr == hdsb_pkg::OFS_TEXT_BASE[s] + 8'(b));
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) text_q[s][b] <= hdsb_pkg::RST_TEXT_BYTE;
            else if (hit) text_q[s][b] <= wdata;
         end
      end
      assign cfg.text_length[s] = text_len_q[s];
   end

   // ---------------------------------------------------------------
   // read side
   // ---------------------------------------------------------------
   function automatic logic [7:0] rd_value(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      for (int r = 0; r < hdsb_pkg::N_SCALAR; r++) begin
         if (a == hdsb_pkg::OFS_SCALAR[r]) v = reg_q[r];
      end
      for (int s = 0; s < 3; s++) begin
         if (a == hdsb_pkg::OFS_TEXT_LEN[s]) v = text_len_q[s];
         if (a >= hdsb_pkg::OFS_TEXT_BASE[s] && a < hdsb_pkg::OFS_TEXT_BASE[s] + hdsb_pkg::TEXT_MAX) begin
            v = text_q[s][5'(a - hdsb_pkg::OFS_TEXT_BASE[s])];
         end
      end
      return v;
   endfunction

   wire       text_ok  = (cfg.text_sel < 2'h3) && ({3'h0, cfg.text_idx} < hdsb_pkg::TEXT_MAX);

   // looked up at the edge: a continuous call would not wake on a store change,
   // so a read right after a write to the same address could return the old byte
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) rdata_q <= 8'h00;
      else if (rd_en) rdata_q <= rd_value(addr);
   end

   assign cfg.text_byte                 = text_ok ? text_q[cfg.text_sel][cfg.text_idx] : 8'h00;
   assign cfg.power_source_select       = reg_q[hdsb_pkg::IX_CONFIG_ONE][hdsb_pkg::POS_POWER_SOURCE];
   assign cfg.ctrl_current_bus_powered  = reg_q[hdsb_pkg::IX_CUR_BUS];
   assign cfg.ctrl_current_self_powered = reg_q[hdsb_pkg::IX_CUR_SELF];
   assign cfg.settle_time               = reg_q[hdsb_pkg::IX_SETTLE];
   assign cfg.fixed_device_mask         = reg_q[hdsb_pkg::IX_FIXED_MASK];
   assign cfg.language_code_high        = reg_q[hdsb_pkg::IX_LANG_HI];
   assign cfg.language_code_low         = reg_q[hdsb_pkg::IX_LANG_LO];
endmodule

/* File: hw/hdsb_byte_pick.sv */
// selects one descriptor byte and the descriptor length
`timescale 1ns/1ns
module hdsb_byte_pick (
   input  hdsb_pkg::hdsb_kind_t kind,
   input  wire logic [1:0]      sel,
   input  wire logic [7:0]      offset,
   output logic      [7:0]      pick_byte,
   output logic      [7:0]      desc_len,
   hdsb_cfg_if.pick             cfg
);
   wire [7:0] current  = cfg.power_source_select ? cfg.ctrl_current_self_powered
                                                 : cfg.ctrl_current_bus_powered;
   wire [7:0] text_len = cfg.text_length[sel];

   wire [7:0] hub_byte =
      (offset == hdsb_pkg::OFS_SETTLE)    ? cfg.settle_time :
      (offset == hdsb_pkg::OFS_CURRENT)   ? current :
      (offset == hdsb_pkg::OFS_REMOVABLE) ? cfg.fixed_device_mask :
      (offset == hdsb_pkg::OFS_PWR_MASK)  ? hdsb_pkg::PWR_MASK_VALUE
                                          : 8'h00;
   wire [7:0] lang_byte =
      (offset == 8'h00)                 ? hdsb_pkg::LANG_DESC_LEN :
      (offset == 8'h01)                 ? hdsb_pkg::TYPE_STRING :
      (offset == hdsb_pkg::OFS_LANG_LO) ? cfg.language_code_low :
                                          cfg.language_code_high;
   wire [7:0] text_b =
      (offset == 8'h00) ? text_len + hdsb_pkg::STR_HDR_LEN :
      (offset == 8'h01) ? hdsb_pkg::TYPE_STRING :
                          cfg.text_byte;

   assign cfg.text_sel = sel;
   assign cfg.text_idx = 5'(offset - hdsb_pkg::STR_HDR_LEN);
   assign pick_byte = (kind == hdsb_pkg::KIND_HUB)  ? hub_byte :
                      (kind == hdsb_pkg::KIND_LANG) ? lang_byte : text_b;
   assign desc_len  = (kind == hdsb_pkg::KIND_HUB)  ? hdsb_pkg::HUB_DESC_LEN :
                      (kind == hdsb_pkg::KIND_LANG) ? hdsb_pkg::LANG_DESC_LEN :
                      text_len + hdsb_pkg::STR_HDR_LEN;
endmodule

/* File: verification/hdsb_host_model.sv */
// upstream host model: issues descriptor requests and collects the answer
`timescale 1ns/1ns
module hdsb_host_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        req_ready,
   input  wire logic        resp_valid,
   input  wire logic [7:0]  resp_data,
   input  wire logic [7:0]  resp_offset,
   input  wire logic        resp_last,
   input  wire logic        resp_empty,
   input  wire logic        resp_stall,
   output logic             req_valid,
   output logic      [7:0]  req_type,
   output logic      [7:0]  req_index,
   output logic      [15:0] req_length
);
   logic       done;
   logic       stalled;
   logic [7:0] got_n;
   logic [7:0] got_b [0:63];
   logic [7:0] got_o [0:63];

   initial begin
      req_valid = 1'b0;
      req_type = 8'h00;
      req_index = 8'h00;
      req_length = 16'h0000;
      done = 1'b0;
      stalled = 1'b0;
      got_n = 8'h00;
   end

   // request held until a rising edge sees ready; released lines show the inverse, not the last value
   task automatic request(input logic [7:0] t, input logic [7:0] ix, input logic [15:0] len);
      @(negedge ref_clk);
      got_n = 8'h00;
      done = 1'b0;
      stalled = 1'b0;
      req_valid = 1'b1;
      req_type = t;
      req_index = ix;
      req_length = len;
      while (req_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      req_valid = 1'b0;
      req_type = ~t;
      req_index = ~ix;
      req_length = ~len;
   endtask

   always @(posedge ref_clk) begin
      if (rst_b && resp_valid === 1'b1) begin
         got_b[got_n[5:0]] <= resp_data;
         got_o[got_n[5:0]] <= resp_offset;
         got_n <= got_n + 8'h01;
      end
      if (rst_b && (resp_last === 1'b1 || resp_empty === 1'b1 || resp_stall === 1'b1)) begin
         done <= 1'b1;
         stalled <= resp_stall;
      end
   end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the hub descriptor and string builder
`timescale 1ns/1ns
module testbench;
   logic        ref_clk, rst_b, cfg_wr_en, cfg_rd_en;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
   logic        req_valid, req_ready, resp_valid, resp_last, resp_empty, resp_stall;
   logic [7:0]  req_type, req_index, resp_data, resp_offset;
   logic [15:0] req_length;
   logic [7:0]  exp_b [0:63];
   int          fail_count, cmp_count, tnum;

   hdsb_top i_hdsb_top (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .req_valid(req_valid),
      .req_type(req_type), .req_index(req_index), .req_length(req_length), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_offset(resp_offset), .resp_last(resp_last),
      .resp_empty(resp_empty), .resp_stall(resp_stall));
   hdsb_host_model i_hdsb_host_model (.ref_clk(ref_clk), .rst_b(rst_b), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_offset(resp_offset), .resp_last(resp_last),
      .resp_empty(resp_empty), .resp_stall(resp_stall), .req_valid(req_valid), .req_type(req_type),
      .req_index(req_index), .req_length(req_length));

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // strobe lowered a full cycle later, so back-to-back calls never touch it twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      cfg_wr_en = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      cfg_rd_en = 1'b1;
      cfg_addr = a;
      @(negedge ref_clk);
      cfg_rd_en = 1'b0;
      chk({8'h00, cfg_rdata}, {8'h00, exp});
   endtask

   task automatic setx4(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
      exp_b[0] = a;
      exp_b[1] = b;
      exp_b[2] = c;
      exp_b[3] = d;
   endtask

   task automatic run(input logic [7:0] t, input logic [7:0] ix, input logic [15:0] len, input int n,
                      input logic [7:0] ofs0, input logic stall);
      int w;
      w = 0;
      i_hdsb_host_model.request(t, ix, len);
      while (i_hdsb_host_model.done !== 1'b1 && w < 100) begin
         @(negedge ref_clk);
         w++;
      end
      chk({15'h0000, i_hdsb_host_model.done}, 16'h0001);
      chk({15'h0000, i_hdsb_host_model.stalled}, {15'h0000, stall});
      chk({8'h00, i_hdsb_host_model.got_n}, n[15:0]);
      for (int k = 0; k < n; k++) begin
         chk({i_hdsb_host_model.got_o[k], i_hdsb_host_model.got_b[k]}, {ofs0 + k[7:0], exp_b[k]});
      end
      tnum++;
      $display("test %0d done", tnum);
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // the sequence needs about 200 cycles; 20000 leaves ample margin
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end

   initial begin
      rst_b = 1'b0;
      cfg_wr_en = 1'b0;
      cfg_rd_en = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      fail_count = 0;
      cmp_count = 0;
      tnum = 0;
      repeat (12) @(negedge ref_clk);
      rst_b = 1'b1;
      rd(8'h10, 8'h00);
      rd(8'h80, 8'h00);
      wr(8'h10, 8'h07);
      wr(8'h11, 8'h06);
      wr(8'h0F, 8'h32);
      wr(8'h0E, 8'h64);
      wr(8'h06, 8'h00);
      rd(8'h0F, 8'h32);
      setx4(8'h07, 8'h32, 8'h06, 8'hFF);
      run(8'h29, 8'h00, 16'h0009, 4, 8'h05, 1'b0);
      wr(8'h06, 8'h80);
      setx4(8'h07, 8'h64, 8'h06, 8'hFF);
      run(8'h00, 8'h00, 16'h0007, 2, 8'h05, 1'b0);
      run(8'h29, 8'h00, 16'h0005, 0, 8'h00, 1'b0);
      wr(8'h12, 8'h04);
      wr(8'h13, 8'h09);
      setx4(8'h04, 8'h03, 8'h09, 8'h04);
      run(8'h03, 8'h00, 16'h00FF, 4, 8'h00, 1'b0);
      wr(8'h15, 8'h1F);
      rd(8'h15, 8'h1E);
      wr(8'h14, 8'h1E);
      wr(8'h15, 8'h03);
      wr(8'h16, 8'h02);
      for (int k = 0; k < 30; k++) begin
         wr(8'h20 + k[7:0], 8'h41 + k[7:0]);
         exp_b[k + 2] = 8'h41 + k[7:0];
      end
      // a fourth product byte is stored but lies beyond the length
      for (int k = 0; k < 4; k++) begin
         wr(8'h40 + k[7:0], 8'h61 + k[7:0]);
      end
      wr(8'h60, 8'h30);
      wr(8'h61, 8'h31);
      exp_b[0] = 8'h20;
      exp_b[1] = 8'h03;
      run(8'h03, 8'h01, 16'h00FF, 32, 8'h00, 1'b0);
      setx4(8'h05, 8'h03, 8'h61, 8'h62);
      exp_b[4] = 8'h63;
      run(8'h03, 8'h02, 16'h00FF, 5, 8'h00, 1'b0);
      setx4(8'h04, 8'h03, 8'h30, 8'h31);
      run(8'h03, 8'h03, 16'h0003, 3, 8'h00, 1'b0);
      run(8'h03, 8'h04, 16'h00FF, 0, 8'h00, 1'b1);
      run(8'h22, 8'h00, 16'h00FF, 0, 8'h00, 1'b1);
      end_sim();
   end
endmodule
